// ---- src/alpwm_pkg.sv ----
// Shared constants, layouts and types of the angle linearization and PWM output stage
package alpwm_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_ANGLE = 8'h08;
    localparam int COEF_ADR_BIT = 7;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_COEF = 32;
    localparam int COEF_W = 12;
    localparam int ANGLE_W = 16;
    localparam int NUM_ERR = 12;
    localparam int FRAC_W = 11;
    localparam int CNT_W = 24;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [13:0] CTRL_RESET = 14'h000d;
    localparam logic [COEF_W-1:0] COEF_RESET = 12'h000;

    // ----------------------------------------------------------------
    // Timing: one period unit is 2.5 us, the frequency grid is built from it
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int UNIT_NS = 2500;
    localparam logic [11:0] PERIOD_BASE_UNITS = 12'h070;
    localparam logic [4:0] PERIOD_FINE_OFFSET = 5'h10;

    // ----------------------------------------------------------------
    // Duty codes as fractions of 65536
    // ----------------------------------------------------------------
    localparam logic [15:0] DUTY_MIN = 16'h0ccd;
    localparam logic [15:0] DUTY_SPAN = 16'he666;
    localparam logic [15:0] ERR_DUTY [0:NUM_ERR-1] = '{
        16'h0ccd, 16'h1b33, 16'h299a, 16'h3800, 16'h4666, 16'h54cd,
        16'h6333, 16'h719a, 16'h8000, 16'h8e66, 16'h9ccd, 16'hab33
    };
    localparam logic [3:0] ERR_NONE = 4'hf;
    localparam logic [3:0] ERR_IDX_MEAN = 4'h5;
    localparam logic [3:0] ERR_IDX_NVM = 4'h8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic mask_main;
        logic mask_analog;
        logic [3:0] pwm_freq;
        logic rsv;
        logic [2:0] pwm_band;
        logic err_style;
        logic err_pwm_en;
        logic coef_range_sel;
        logic lin_en;
    } alpwm_cfg_s;

    typedef struct packed {
        logic watchdog_fault;
        logic osc_freq_fault;
        logic selftest_fault;
        logic pll_unlock_fault;
        logic zero_cross_check_fault;
        logic mean_calc_fault;
        logic analog_supply_low;
        logic main_supply_low;
        logic field_weak_fault;
        logic nvm_corrected_fault;
        logic clip_fault;
        logic field_strong_fault;
        logic temp_window_fault;
    } alpwm_fault_s;

    typedef enum logic [1:0] {PW_ANGLE, PW_ERR_FLOAT, PW_ERR_CODE} alpwm_mode_e;

endpackage

// ---- src/alpwm_top.sv ----
// Angle linearization and PWM output stage with error duty codes and Wishbone registers
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module alpwm_top import alpwm_pkg::*; #(
    parameter int unsigned UNIT_CYCLES = UNIT_NS / CLK_PERIOD_NS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [ANGLE_W-1:0] angle_i,
    input wire logic angle_valid_i,
    input wire alpwm_fault_s flt_i,
    output logic [ANGLE_W-1:0] angle_o,
    output logic angle_valid_o,
    output logic pwm_o,
    output logic pwm_oe_n_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [CNT_W-1:0] scale_duty(input logic [CNT_W-1:0] p, input logic [15:0] d);
        logic [39:0] t;
        t = 40'(p) * 40'(d);
        return t[39:16];
    endfunction

    function automatic logic [3:0] top_err(input logic [NUM_ERR-1:0] a);
        logic [3:0] r;
        r = ERR_NONE;
        for (int i = NUM_ERR - 1; i >= 0; i--) begin
            if (a[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    alpwm_cfg_s cfg, next_cfg;
    logic [COEF_W-1:0] coef [0:NUM_COEF-1];
    logic [COEF_W-1:0] next_coef [0:NUM_COEF-1];
    logic [31:0] next_dat;
    logic next_ack;
    logic [NUM_ERR-1:0] err_act;
    logic [3:0] err_idx;
    alpwm_mode_e mode, next_mode;
    logic [ANGLE_W-1:0] lin_angle, next_lin_angle;

    always_comb begin
        logic req;
        logic [15:0] cw;
        logic [COEF_W-1:0] c;
        req = wb_cyc_i && wb_stb_i;
        cw = {2'b00, cfg};
        c = coef[wb_adr_i[6:2]];
        next_ack = req && !wb_ack_o;
        next_dat = 32'h0;
        next_cfg = cfg;
        next_coef = coef;
        if (req && !wb_ack_o) begin
            if (wb_adr_i[COEF_ADR_BIT]) begin
                next_dat = {20'h0, c};
            end else if (wb_adr_i[7:2] == ADR_CTRL[7:2]) begin
                next_dat = {18'h0, cfg};
            end else if (wb_adr_i[7:2] == ADR_STATUS[7:2]) begin
                next_dat = {6'h0, mode, 4'h0, err_idx, 4'h0, err_act};
            end else if (wb_adr_i[7:2] == ADR_ANGLE[7:2]) begin
                next_dat = {16'h0, lin_angle};
            end
        end
        // Writes land on the edge where the master samples ack
        if (req && wb_ack_o && wb_we_i) begin
            if (wb_adr_i[COEF_ADR_BIT]) begin
                if (wb_sel_i[0]) begin
                    c[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    c[11:8] = wb_dat_i[11:8];
                end
                next_coef[wb_adr_i[6:2]] = c;
            end else if (wb_adr_i[7:2] == ADR_CTRL[7:2]) begin
                if (wb_sel_i[0]) begin
                    cw[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    cw[15:8] = wb_dat_i[15:8];
                end
                next_cfg = alpwm_cfg_s'(cw[13:0]);
                next_cfg.rsv = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg <= alpwm_cfg_s'(CTRL_RESET);
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            cfg <= next_cfg;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // Coefficient store, one register per correction point
    generate
        for (genvar g = 0; g < NUM_COEF; g++) begin : g_coef
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    coef[g] <= COEF_RESET;
                end else begin
                    coef[g] <= next_coef[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Linearization pipeline
    // ----------------------------------------------------------------
    logic s1_valid, next_s1_valid;
    logic [ANGLE_W-1:0] s1_angle, next_s1_angle;
    logic [COEF_W-1:0] s1_c0, s1_c1, next_s1_c0, next_s1_c1;
    logic [FRAC_W-1:0] s1_frac, next_s1_frac;
    logic next_angle_valid;

    always_comb begin
        logic [4:0] idx;
        logic signed [12:0] diff;
        logic signed [24:0] prod;
        logic signed [24:0] acc;
        logic [12:0] interp;
        logic [15:0] corr;
        corr = 16'h0000;
        idx = angle_i[ANGLE_W-1:FRAC_W];
        next_s1_valid = angle_valid_i;
        next_s1_angle = angle_valid_i ? angle_i : s1_angle;
        next_s1_frac = angle_valid_i ? angle_i[FRAC_W-1:0] : s1_frac;
        next_s1_c0 = angle_valid_i ? coef[idx] : s1_c0;
        next_s1_c1 = angle_valid_i ? coef[5'(idx + 5'h01)] : s1_c1;
        diff = $signed({s1_c1[11], s1_c1}) - $signed({s1_c0[11], s1_c0});
        prod = diff * $signed({1'b0, s1_frac});
        acc = $signed({{2{s1_c0[11]}}, s1_c0, 11'h000}) + prod;
        interp = acc[23:11];
        // Coefficient LSB weight follows the range select
        if (cfg.coef_range_sel) begin
            corr = {interp[12], interp, 2'b00};
        end else begin
            corr = {{2{interp[12]}}, interp, 1'b0};
        end
        next_angle_valid = s1_valid;
        next_lin_angle = lin_angle;
        if (s1_valid) begin
            // Both paths go through the same two stages
            next_lin_angle = cfg.lin_en ? s1_angle - corr : s1_angle;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_valid <= 1'b0;
            s1_angle <= '0;
            s1_frac <= '0;
            s1_c0 <= '0;
            s1_c1 <= '0;
            lin_angle <= '0;
            angle_o <= '0;
            angle_valid_o <= 1'b0;
        end else begin
            s1_valid <= next_s1_valid;
            s1_angle <= next_s1_angle;
            s1_frac <= next_s1_frac;
            s1_c0 <= next_s1_c0;
            s1_c1 <= next_s1_c1;
            lin_angle <= next_lin_angle;
            angle_o <= next_lin_angle;
            angle_valid_o <= next_angle_valid;
        end
    end

    // ----------------------------------------------------------------
    // Error collection and priority
    // ----------------------------------------------------------------
    logic wd_lat, st_lat, pend_mean, pend_nvm;
    logic next_wd_lat, next_st_lat, next_pend_mean, next_pend_nvm;
    logic wrap;
    logic consume_mean, consume_nvm;

    always_comb begin
        err_act[0] = wd_lat || flt_i.watchdog_fault;
        err_act[1] = flt_i.osc_freq_fault;
        err_act[2] = st_lat || flt_i.selftest_fault;
        err_act[3] = flt_i.pll_unlock_fault;
        err_act[4] = flt_i.zero_cross_check_fault;
        err_act[5] = pend_mean || flt_i.mean_calc_fault;
        err_act[6] = (flt_i.analog_supply_low && !cfg.mask_analog)
                     || (flt_i.main_supply_low && !cfg.mask_main);
        err_act[7] = flt_i.field_weak_fault;
        err_act[8] = pend_nvm || flt_i.nvm_corrected_fault;
        err_act[9] = flt_i.clip_fault;
        err_act[10] = flt_i.field_strong_fault;
        err_act[11] = flt_i.temp_window_fault;
        err_idx = top_err(err_act);
        next_wd_lat = err_act[0];
        next_st_lat = err_act[2];
        // A new event in the consuming cycle stays pending
        next_pend_mean = (pend_mean && !consume_mean) || flt_i.mean_calc_fault;
        next_pend_nvm = (pend_nvm && !consume_nvm) || flt_i.nvm_corrected_fault;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_lat <= 1'b0;
            st_lat <= 1'b0;
            pend_mean <= 1'b0;
            pend_nvm <= 1'b0;
        end else begin
            wd_lat <= next_wd_lat;
            st_lat <= next_st_lat;
            pend_mean <= next_pend_mean;
            pend_nvm <= next_pend_nvm;
        end
    end

    // ----------------------------------------------------------------
    // PWM generator
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [CNT_W-1:0] period_len, next_period_len;
    logic [CNT_W-1:0] high_len, next_high_len;
    logic [CNT_W-1:0] base_cycles;
    logic [15:0] angle_duty;
    logic err_shown;
    logic next_pwm, next_oe_n;

    always_comb begin
        logic [11:0] base_units;
        base_units = PERIOD_BASE_UNITS + (12'(cfg.pwm_freq + PERIOD_FINE_OFFSET) << cfg.pwm_band);
        base_cycles = CNT_W'(32'(base_units) * 32'(UNIT_CYCLES));
        angle_duty = DUTY_MIN + 16'((32'(lin_angle[15:4]) * 32'(DUTY_SPAN)) >> 12);
        wrap = (cnt == period_len - 24'h000001);
        err_shown = cfg.err_pwm_en && (err_idx != ERR_NONE);
        consume_mean = wrap && err_shown && (err_idx == ERR_IDX_MEAN);
        consume_nvm = wrap && err_shown && (err_idx == ERR_IDX_NVM);
        next_cnt = cnt + 24'h000001;
        next_mode = mode;
        next_period_len = period_len;
        next_high_len = high_len;
        if (wrap) begin
            // New settings only take effect on a period boundary
            next_cnt = '0;
            if (err_shown && !cfg.err_style) begin
                next_mode = PW_ERR_FLOAT;
                next_period_len = base_cycles;
                next_high_len = '0;
            end else if (err_shown) begin
                next_mode = PW_ERR_CODE;
                next_period_len = {base_cycles[CNT_W-2:0], 1'b0};
                next_high_len = scale_duty({base_cycles[CNT_W-2:0], 1'b0}, ERR_DUTY[err_idx]);
            end else begin
                next_mode = PW_ANGLE;
                next_period_len = base_cycles;
                next_high_len = scale_duty(base_cycles, angle_duty);
            end
        end
        next_pwm = next_cnt < next_high_len;
        next_oe_n = (next_mode == PW_ERR_FLOAT);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
            period_len <= 24'h000001;
            high_len <= '0;
            mode <= PW_ANGLE;
            pwm_o <= 1'b0;
            pwm_oe_n_o <= 1'b1;
        end else begin
            cnt <= next_cnt;
            period_len <= next_period_len;
            high_len <= next_high_len;
            mode <= next_mode;
            pwm_o <= next_pwm;
            pwm_oe_n_o <= next_oe_n;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    watchdog_latch_a: assert property (flt_i.watchdog_fault |=> err_act[0] ##1 err_act[0])
        else $error("watchdog fault not latched");
    selftest_latch_a: assert property (flt_i.selftest_fault |=> err_act[2] ##1 err_act[2])
        else $error("selftest fault not latched");
    top_code_a: assert property (wrap && cfg.err_pwm_en && cfg.err_style && err_act[0]
        |=> mode == PW_ERR_CODE && high_len == scale_duty(period_len, 16'h0ccd))
        else $error("watchdog code wrong");
    float_pin_a: assert property (wrap && cfg.err_pwm_en && !cfg.err_style && (|err_act)
        |=> pwm_oe_n_o && !pwm_o)
        else $error("pin not floated on error");
    err_gate_a: assert property (wrap && !cfg.err_pwm_en |=> mode == PW_ANGLE && !pwm_oe_n_o)
        else $error("error reached pin while disabled");
    mean_once_a: assert property (consume_mean && !flt_i.mean_calc_fault |=> !pend_mean)
        else $error("averaging fault not cleared after showing");
    nvm_once_a: assert property (consume_nvm && !flt_i.nvm_corrected_fault |=> !pend_nvm)
        else $error("memory error not cleared after showing");
    supply_mask_a: assert property (flt_i.analog_supply_low && cfg.mask_analog && !flt_i.main_supply_low
        |-> !err_act[6])
        else $error("masked supply fault shown");
    latency_a: assert property (angle_valid_i |-> ##2 angle_valid_o)
        else $error("angle latency wrong");
    bypass_path_a: assert property (angle_valid_i && !cfg.lin_en ##1 !cfg.lin_en
        |=> angle_o == $past(angle_i, 2))
        else $error("bypass angle changed");
    angle_duty_a: assert property (mode == PW_ANGLE && cnt == '0 && period_len > 24'h000014
        |-> high_len >= period_len / 20 && high_len <= period_len - period_len / 20)
        else $error("angle duty out of 5..95 percent");
    code_period_a: assert property (wrap && next_mode == PW_ERR_CODE
        |=> period_len == ($past(base_cycles) << 1))
        else $error("error period not doubled");

    angle_period_c: cover property (wrap ##1 mode == PW_ANGLE);
    code_period_c: cover property (wrap ##1 mode == PW_ERR_CODE);
    float_period_c: cover property (wrap ##1 mode == PW_ERR_FLOAT);
    mean_shown_c: cover property (consume_mean);
    nvm_shown_c: cover property (consume_nvm);

endmodule

`default_nettype wire

// ---- test/alpwm_host_model.sv ----
// Host-side model that decodes the duty cycle of the PWM pin
`timescale 1ns/1ps
`default_nettype none
module alpwm_host_model (
    input wire logic clk_i,
    input wire logic pwm_i,
    input wire logic pwm_oe_n_i,
    output int hi_cnt,
    output int per_cnt,
    output int rises
);
    // A floated pin reads as low, so no edge is seen
    logic seen_high;
    logic last_high;
    int cnt;
    int hcnt;
    assign seen_high = !pwm_oe_n_i && pwm_i;
    initial begin
        last_high = 1'b0;
        cnt = 0;
        hcnt = 0;
        hi_cnt = 0;
        per_cnt = 0;
        rises = 0;
    end
    // Each rising edge closes one period and reports its high time
    always @(posedge clk_i) begin
        if (seen_high && !last_high) begin
            hi_cnt <= hcnt;
            per_cnt <= cnt;
            rises <= rises + 1;
            cnt <= 1;
            hcnt <= 1;
        end else begin
            cnt <= cnt + 1;
            hcnt <= hcnt + int'(seen_high);
        end
        last_high <= seen_high;
    end
endmodule
`default_nettype wire

// ---- test/alpwm_top_tb.sv ----
// Self-checking bench for the angle linearization and PWM output stage
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module alpwm_top_tb import alpwm_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ang_v = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, wb_dat_o;
    logic [15:0] ang = 16'h0000, angle_o;
    logic wb_ack_o, angle_valid_o, pwm_o, pwm_oe_n_o;
    logic [12:0] flt_v = 13'h0000;
    logic [11:0] coef [0:31];
    int failures = 0, check_count = 0, seed = 80769;
    int hi_cnt, per_cnt, rises;
    // Error duty codes in thousandths of a percent, highest priority first
    localparam int PM [0:11] = '{5000, 10625, 16250, 21875, 27500, 33125, 38750, 44375, 50000, 55625, 61250, 66875};

    always #2 clk_i = ~clk_i;

    alpwm_top #(.UNIT_CYCLES(1)) alpwm_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .angle_i(ang),
        .angle_valid_i(ang_v), .flt_i(alpwm_fault_s'(flt_v)), .angle_o(angle_o), .angle_valid_o(angle_valid_o),
        .pwm_o(pwm_o), .pwm_oe_n_o(pwm_oe_n_o)
    );
    alpwm_host_model alpwm_host_model_inst (
        .clk_i(clk_i), .pwm_i(pwm_o), .pwm_oe_n_i(pwm_oe_n_o), .hi_cnt(hi_cnt), .per_cnt(per_cnt), .rises(rises)
    );

    // Thousandths of a percent to fraction of 65536, rounded
    function automatic longint dcode(input longint pm);
        return (pm * 65536 + 50000) / 100000;
    endfunction

    function automatic logic [15:0] lin_exp(input logic [15:0] a, input logic [1:0] c);
        int i, f, c0, c1, corr;
        i = int'(a[15:11]);
        f = int'(a[10:0]);
        c0 = $signed(coef[i]);
        c1 = $signed(coef[(i + 1) % 32]);
        corr = c0 + (((c1 - c0) * f) >>> 11);
        if (!c[0]) return a;
        return a - 16'(corr * (c[1] ? 4 : 2));
    endfunction

    task automatic tally_and_finish;
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            failures++;
            tally_and_finish;
        end
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wait_rise;
        int r, n;
        r = rises;
        n = 0;
        while (rises == r && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        if (rises == r) begin
            failures++;
            tally_and_finish;
        end
    endtask

    // Waits out n periods, then checks the last of them
    task automatic pwm_chk(input int n, input longint per, input longint d);
        repeat (n) wait_rise;
        `CHK(per_cnt, int'(per))
        `CHK(hi_cnt, int'(per * d / 65536))
    endtask

    task automatic send_angle(input logic [15:0] a);
        @(posedge clk_i);
        ang <= a;
        ang_v <= 1'b1;
        @(posedge clk_i);
        ang_v <= 1'b0;
    endtask

    initial begin
        logic [31:0] q;
        logic [1:0] c;
        logic [15:0] a;
        int b, f, n;
        longint p, ad;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ADR_CTRL, 32'h0, q);
        `CHK(q, 32'h0000_000d)
        wb(1'b0, ADR_STATUS, 32'h0, q);
        `CHK(q, 32'h000f_0000)
        wb(1'b0, 8'h40, 32'h0, q);
        `CHK(q, 32'h0000_0000)
        for (int i = 0; i < 32; i++) begin
            coef[i] = 12'($random(seed));
            wb(1'b1, 8'h80 + 8'(4 * i), {20'hfffff, coef[i]}, q);
        end
        wb(1'b0, 8'hfc, 32'h0, q);
        `CHK(q, {20'h0, coef[31]})
        // Corner angles first: wrap segment, then an exact point
        for (int k = 0; k < 48; k++) begin
            if (k % 16 == 0) begin
                c = (k == 0) ? 2'h1 : (k == 16) ? 2'h3 : 2'h2;
                wb(1'b1, ADR_CTRL, {30'h0, c}, q);
            end
            a = (k == 0) ? 16'hffff : (k == 1) ? 16'h0800 : 16'($random(seed));
            send_angle(a);
            repeat (1) @(posedge clk_i);
            @(negedge clk_i);
            `CHK(angle_valid_o, 1'b1)
            `CHK(angle_o, lin_exp(a, c))
        end
        wb(1'b0, 8'h94, 32'h0, q);
        `CHK(q, {20'h0, coef[5]})
        a = 16'($random(seed));
        send_angle(a);
        wb(1'b0, ADR_ANGLE, 32'h0, q);
        `CHK(q, {16'h0, a})
        ad = dcode(5000) + longint'(a[15:4]) * dcode(90000) / 4096;
        for (int s = 0; s < 3; s++) begin
            b = (s == 0) ? 0 : (s == 1) ? 3 : 7;
            f = (s == 0) ? 0 : (s == 1) ? 5 : 15;
            wb(1'b1, ADR_CTRL, 32'((b << 4) | (f << 8)), q);
            pwm_chk(3, 112 + ((16 + f) << b), ad);
        end
        p = 128;
        flt_v[5] <= 1'b1;
        wb(1'b1, ADR_CTRL, 32'h200c, q);
        pwm_chk(3, p, ad);
        flt_v[6:5] <= 2'b10;
        wb(1'b1, ADR_CTRL, 32'h100c, q);
        pwm_chk(3, p, ad);
        wb(1'b1, ADR_CTRL, 32'h0008, q);
        pwm_chk(3, p, ad);
        wb(1'b1, ADR_CTRL, 32'h000c, q);
        pwm_chk(3, 2 * p, dcode(PM[6]));
        flt_v <= 13'h0000;
        // Faults raised from lowest to highest, so each new one wins
        for (int i = 11; i >= 0; i--) begin
            wait_rise;
            flt_v[i > 6 ? 11 - i : 12 - i] <= 1'b1;
            if (i == 5 || i == 8) begin
                @(posedge clk_i);
                flt_v[i > 6 ? 11 - i : 12 - i] <= 1'b0;
            end
            pwm_chk(2, 2 * p, dcode(PM[i]));
            if (i == 5 || i == 8) begin
                pwm_chk(1, 2 * p, dcode(PM[i + 1]));
            end
        end
        wb(1'b1, ADR_CTRL, 32'h0004, q);
        repeat (600) @(posedge clk_i);
        n = 0;
        repeat (300) begin
            @(posedge clk_i);
            n += int'(pwm_oe_n_o === 1'b1);
        end
        `CHK(n, 300)
        wb(1'b0, ADR_STATUS, 32'h0, q);
        `CHK(q[25:16], 10'h100)
        `CHK(q[11:0], 12'hedf)
        flt_v <= 13'h0000;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ADR_STATUS, 32'h0, q);
        `CHK(q, 32'h000f_0000)
        tally_and_finish;
    end
endmodule
`default_nettype wire
